// ===== rtl/picg_consts.vh
/*
 constants for the input capture gearbox: capture modes, delay line
 size, fifo shape and synchroniser depth.
 assumes it is included by its bare name from the design files.
*/
`ifndef PICG_CONSTS_VH
`define PICG_CONSTS_VH

// ==================================================================
// capture modes
`define PICG_MODE_W 2
`define PICG_MODE_SDR 2'h0
`define PICG_MODE_DDR 2'h1
`define PICG_MODE_GEAR 2'h2

// ==================================================================
// input delay
`define PICG_DEL_W 4
`define PICG_DEL_TAPS 16
`define PICG_FIXED_DEL 4'h3

// ==================================================================
// pair fifo and synchroniser
`define PICG_PAIR_W 2
`define PICG_FIFO_DEPTH 16
`define PICG_FIFO_AW 4
`define PICG_SYNC_W 2

`endif

// ===== rtl/picg_capture.v
/*
 input register stage of one i/o cell pair: bypass taps, fixed or
 dynamic input delay, sdr capture, ddr capture on strobe edges with
 retiming into the system clock, and a 2-to-4 gearbox. also holds the
 pair fifo that sits between ddr capture and the core.
 assumes pad data and strobe arrive asynchronously and that the
 strobe is slow enough (at least 4 system clocks per half period)
 for its edges to be found by oversampling.
*/
`timescale 1ns/10ps
`default_nettype none
`include "picg_consts.vh"


// ==================================================================
// pair fifo
module picg_fifo #(
   parameter W = 2,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock, reset, enable
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire ce_i,
   // fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   // drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr_r;
   reg [AW:0] rd_ptr_r;
   wire full;
   wire empty;
   wire push;
   wire pop;

   assign empty = (wr_ptr_r == rd_ptr_r);
   assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) &&
      (wr_ptr_r[AW] != rd_ptr_r[AW]);
   assign in_ready_o = ~full;
   assign out_valid_o = ~empty;
   assign out_data_o = mem[rd_ptr_r[AW-1:0]];
   assign push = ce_i & in_valid_i & ~full;
   assign pop = ce_i & out_ready_i & ~empty;

   // storage has no reset; only the pointers carry state
   always @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data_i;
      end
   end

   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_r <= {(AW+1){1'b0}};
         rd_ptr_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + {{AW{1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

// ==================================================================
// capture stage
module picg_capture (
   // clock, reset, enable
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire ce_i,
   // pad side
   input wire pad_data_in_i,
   input wire dqs_strobe_i,
   // configuration from the core
   input wire [`PICG_MODE_W-1:0] mode_sel_i,
   input wire delay_en_i,
   input wire delay_dyn_i,
   input wire [`PICG_DEL_W-1:0] dyn_delay_sel_i,
   input wire ddr_retime_clk_invert_i,
   input wire strobe_tap_en_i,
   // bypass taps
   output wire comb_bypass_out_o,
   output wire clock_tap_out_o,
   output wire strobe_delay_in_o,
   // sdr output
   output wire sdr_registered_out_o,
   // ddr output
   output wire ddr_valid_o,
   input wire ddr_ready_i,
   output wire rise_stream_o,
   output wire fall_stream_o,
   // gearbox output
   output wire gear_valid_o,
   output wire gear_out_true_0_o,
   output wire gear_out_true_1_o,
   output wire gear_out_comp_0_o,
   output wire gear_out_comp_1_o,
   // status
   output wire capture_ready_o,
   output wire overrun_o
);
   // ===============================================================
   // bypass taps
   // pad as single input
   assign comb_bypass_out_o = pad_data_in_i;
   assign clock_tap_out_o = pad_data_in_i;
   assign strobe_delay_in_o = strobe_tap_en_i & pad_data_in_i;

   // ===============================================================
   // synchronisers, bit 0 pad data, bit 1 strobe
   wire [1:0] async_in;
   wire [1:0] sync_out;
   assign async_in = {dqs_strobe_i, pad_data_in_i};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         reg meta_r;
         reg sync_r;
         always @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
            end else if (ce_i) begin
               meta_r <= async_in[gi];
               sync_r <= meta_r;
            end
         end
         assign sync_out[gi] = sync_r;
      end
   endgenerate

   // ===============================================================
   // input delay line
   reg [`PICG_DEL_TAPS-1:0] dly_line_r;
   wire [`PICG_DEL_W-1:0] tap_sel;
   wire cap_data;

   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dly_line_r <= {`PICG_DEL_TAPS{1'b0}};
      end else if (ce_i) begin
         dly_line_r <= {dly_line_r[`PICG_DEL_TAPS-2:0], sync_out[0]};
      end
   end

   assign tap_sel = delay_dyn_i ? dyn_delay_sel_i : `PICG_FIXED_DEL;
   assign cap_data = delay_en_i ? dly_line_r[tap_sel] : sync_out[0];

   // ===============================================================
   // sdr capture
   reg sdr_r;
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sdr_r <= 1'b0;
      end else if (ce_i && mode_sel_i == `PICG_MODE_SDR) begin
         sdr_r <= cap_data;
      end
   end
   assign sdr_registered_out_o = sdr_r;

   // ===============================================================
   // strobe edge capture
   reg strb_d_r;
   reg rise_cap_r;
   reg fall_cap_r;
   reg pair_evt_r;
   reg pair_evt_d_r;
   wire is_ddr;
   wire strb_rise;
   wire strb_fall;

   assign is_ddr = (mode_sel_i == `PICG_MODE_DDR) ||
      (mode_sel_i == `PICG_MODE_GEAR);
   assign strb_rise = sync_out[1] & ~strb_d_r;
   assign strb_fall = ~sync_out[1] & strb_d_r;

   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         strb_d_r <= 1'b0;
         rise_cap_r <= 1'b0;
         fall_cap_r <= 1'b0;
         pair_evt_r <= 1'b0;
         pair_evt_d_r <= 1'b0;
      end else if (ce_i) begin
         strb_d_r <= sync_out[1];
         if (is_ddr && strb_rise) begin
            rise_cap_r <= cap_data;
         end
         if (is_ddr && strb_fall) begin
            fall_cap_r <= cap_data;
         end
         // a pair is complete once its falling half is held
         pair_evt_r <= is_ddr & strb_fall;
         pair_evt_d_r <= pair_evt_r;
      end
   end

   // ===============================================================
   // retime into the fifo
   wire push_valid;
   wire push_ready;
   wire [`PICG_PAIR_W-1:0] push_data;
   reg overrun_r;

   // inverted retiming takes the later phase
   assign push_valid = ddr_retime_clk_invert_i ? pair_evt_d_r : pair_evt_r;
   // rise stream in bit 0, fall stream in bit 1
   assign push_data = {fall_cap_r, rise_cap_r};
   assign capture_ready_o = push_ready;

   // the pad cannot be stalled, so a pair meeting a full fifo is lost
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         overrun_r <= 1'b0;
      end else if (ce_i) begin
         if (push_valid && !push_ready) begin
            overrun_r <= 1'b1;
         end else if (!is_ddr) begin
            overrun_r <= 1'b0;
         end
      end
   end
   assign overrun_o = overrun_r;

   wire pop_valid;
   wire pop_ready;
   wire [`PICG_PAIR_W-1:0] pop_data;

   picg_fifo #(
      .W(`PICG_PAIR_W),
      .DEPTH(`PICG_FIFO_DEPTH),
      .AW(`PICG_FIFO_AW)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .in_data_i(push_data),
      .out_valid_o(pop_valid),
      .out_ready_i(pop_ready),
      .out_data_o(pop_data)
   );

   // ===============================================================
   // drain: ddr pairs or gearbox quads
   reg rise_r;
   reg fall_r;
   reg ddr_valid_r;
   reg gear_phase_r;
   reg gear_valid_r;
   reg [3:0] gear_r;
   wire is_gear;
   wire pop;

   assign is_gear = (mode_sel_i == `PICG_MODE_GEAR);
   assign pop_ready = ddr_ready_i;
   assign pop = pop_valid & pop_ready;

   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rise_r <= 1'b0;
         fall_r <= 1'b0;
         ddr_valid_r <= 1'b0;
         gear_phase_r <= 1'b0;
         gear_valid_r <= 1'b0;
         gear_r <= 4'h0;
      end else if (ce_i) begin
         ddr_valid_r <= pop & ~is_gear;
         gear_valid_r <= pop & is_gear & gear_phase_r;
         if (!is_gear) begin
            gear_phase_r <= 1'b0;
         end
         if (pop && !is_gear) begin
            rise_r <= pop_data[0];
            fall_r <= pop_data[1];
         end
         if (pop && is_gear) begin
            gear_phase_r <= ~gear_phase_r;
            if (gear_phase_r) begin
               gear_r[3:2] <= pop_data;
            end else begin
               gear_r[1:0] <= pop_data;
            end
         end
      end
   end

   assign rise_stream_o = rise_r;
   assign fall_stream_o = fall_r;
   assign ddr_valid_o = ddr_valid_r;
   assign gear_valid_o = gear_valid_r;
   assign gear_out_true_0_o = gear_r[0];
   assign gear_out_true_1_o = gear_r[1];
   assign gear_out_comp_0_o = gear_r[2];
   assign gear_out_comp_1_o = gear_r[3];
endmodule
`default_nettype wire

// ===== testbench/picg_capture_asserts.sv
/* port properties of the capture stage.
 assumes a bind to picg_capture and the constants header. */
`timescale 1ns/10ps
`default_nettype none
`include "picg_consts.vh"
// ==============================================================
// checker
module picg_capture_asserts (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // inputs
   input wire logic ce_i,
   input wire logic pad_data_in_i,
   input wire logic [1:0] mode_sel_i,
   input wire logic delay_en_i,
   input wire logic strobe_tap_en_i,
   input wire logic ddr_ready_i,
   // outputs
   input wire logic comb_bypass_out_o,
   input wire logic clock_tap_out_o,
   input wire logic strobe_delay_in_o,
   input wire logic sdr_registered_out_o,
   input wire logic ddr_valid_o,
   input wire logic rise_stream_o,
   input wire logic fall_stream_o,
   input wire logic gear_valid_o,
   input wire logic capture_ready_o,
   input wire logic overrun_o
);
   logic sdr_on, ddr_on, no_ddr;
   assign sdr_on = ce_i && !delay_en_i && mode_sel_i == `PICG_MODE_SDR;
   assign ddr_on = ce_i && mode_sel_i == `PICG_MODE_DDR;
   // modes 0 and 3 never capture pairs
   assign no_ddr = ce_i && (mode_sel_i[0] == mode_sel_i[1]);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_sdr;
      sdr_on [*4];
   endsequence
   // three cycles so a pop decided in another mode has landed
   sequence s_ddr;
      ddr_on [*3];
   endsequence
   a_bypass_taps: assert property (
      comb_bypass_out_o == pad_data_in_i &&
      clock_tap_out_o == pad_data_in_i &&
      strobe_delay_in_o == (pad_data_in_i && strobe_tap_en_i))
      else $error("bypass tap wrong");
   a_sdr_latency: assert property (
      s_sdr |-> sdr_registered_out_o == $past(pad_data_in_i, 3))
      else $error("sdr sample wrong");
   a_sdr_frozen: assert property (
      (mode_sel_i != `PICG_MODE_SDR) [*2] |-> $stable(sdr_registered_out_o))
      else $error("sdr moved");
   a_valid_ready: assert property (
      $rose(ddr_valid_o) |-> $past(ddr_ready_i))
      else $error("pop without ready");
   a_overrun_full: assert property (
      $rose(overrun_o) |-> !$past(capture_ready_o))
      else $error("overrun while not full");
   // three idle cycles, so a late pair push can no longer set it
   // overrun clears outside ddr
   a_overrun_clear: assert property (
      no_ddr [*3] |=> !overrun_o)
      else $error("overrun kept");
   a_gear_mode: assert property (
      $rose(gear_valid_o) |-> $past(mode_sel_i) == `PICG_MODE_GEAR)
      else $error("quad outside gearbox");
   a_stream_hold: assert property (
      s_ddr ##0 !ddr_valid_o |-> $stable(rise_stream_o) &&
      $stable(fall_stream_o))
      else $error("stream moved");
endmodule
bind picg_capture picg_capture_asserts u_chk (
   .clk_sys_i, .reset_n_i, .ce_i, .pad_data_in_i, .mode_sel_i,
   .delay_en_i, .strobe_tap_en_i, .ddr_ready_i, .comb_bypass_out_o,
   .clock_tap_out_o, .strobe_delay_in_o, .sdr_registered_out_o,
   .ddr_valid_o, .rise_stream_o, .fall_stream_o, .gear_valid_o,
   .capture_ready_o, .overrun_o);
`default_nettype wire

// ===== testbench/picg_ddr_src.sv
/* ddr source: one strobe and one data line, 320 ns per pair.
 assumes it is the only driver of pad and strobe. */
`timescale 1ns/10ps
`default_nettype none
// ==============================================================
// transmitter
module picg_ddr_src (
   // pad side
   output var logic pad_o,
   output var logic dqs_o
);
   initial begin
      pad_o = 1'b0;
      dqs_o = 1'b0;
   end
   task automatic send_pair(input logic r, input logic f);
      pad_o = r;
      #80;
      dqs_o = 1'b1;
      #80;
      pad_o = f;
      #80;
      dqs_o = 1'b0;
      #80;
      // data is left standing; the next frame replaces it
   endtask
   task automatic set_pad(input logic v);
      pad_o = v;
   endtask
endmodule
`default_nettype wire

// ===== testbench/picg_capture_test.sv
/* self-checking bench of the capture stage.
 assumes picg_ddr_src drives pad and strobe. */
`timescale 1ns/10ps
`default_nettype none
`include "picg_consts.vh"
// ==============================================================
// bench
module picg_capture_test;
   logic clk, rst_n, ce, den, ddyn, inv, tap, rdy;
   logic [1:0] mode, q4;
   logic [3:0] dsel;
   logic [7:0] rnd;
   wire logic pad, dqs, comb, ctap, stap, sdr, dv, rs, fs, gv;
   wire logic g0, g1, g2, g3, crdy, ovr;
   logic [1:0] qd [$];
   logic [3:0] qg [$];
   int error_cnt, n_tests, lat;
   picg_capture DUT (.clk_sys_i(clk), .reset_n_i(rst_n), .ce_i(ce),
      .pad_data_in_i(pad), .dqs_strobe_i(dqs), .mode_sel_i(mode),
      .delay_en_i(den), .delay_dyn_i(ddyn), .dyn_delay_sel_i(dsel),
      .ddr_retime_clk_invert_i(inv), .strobe_tap_en_i(tap),
      .comb_bypass_out_o(comb), .clock_tap_out_o(ctap),
      .strobe_delay_in_o(stap), .sdr_registered_out_o(sdr),
      .ddr_valid_o(dv), .ddr_ready_i(rdy), .rise_stream_o(rs),
      .fall_stream_o(fs), .gear_valid_o(gv), .gear_out_true_0_o(g0),
      .gear_out_true_1_o(g1), .gear_out_comp_0_o(g2),
      .gear_out_comp_1_o(g3), .capture_ready_o(crdy), .overrun_o(ovr));
   picg_ddr_src src (.pad_o(pad), .dqs_o(dqs));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d of %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // a pair lasts 8 clocks, so callers stay on falling edges
   task automatic pair(input logic r, input logic f, input logic keep);
      if (keep)
         qd.push_back({f, r});
      src.send_pair(r, f);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #100000;
      error_cnt++;
      tally_and_finish;
   end
   always @(posedge clk) begin
      if (dv === 1'b1 && mode == `PICG_MODE_DDR)
         check({2'h0, fs, rs}, {2'h0, qd.pop_front()});
      if (gv === 1'b1)
         check({g0, g1, g2, g3}, qg.pop_front());
   end
   initial begin
      error_cnt = 0;
      n_tests = 0;
      rnd = 8'h51;
      {rst_n, den, ddyn, inv, tap} = 5'h0;
      {ce, rdy} = 2'h3;
      mode = `PICG_MODE_SDR;
      dsel = 4'h0;
      cyc(1);
      check({2'h0, crdy, sdr}, 4'h2);
      cyc(1);
      rst_n = 1'b1;
      repeat (24) begin
         rnd = lfsr(rnd);
         src.set_pad(rnd[0]);
         tap = rnd[1];
         cyc(1);
         check(4'(comb), 4'(rnd[0]));
         check({2'h0, ctap, stap}, {2'h0, rnd[0], &rnd[1:0]});
      end
      den = 1'b1;
      for (int i = 0; i < 4; i++) begin
         ddyn = (i != 3);
         dsel = 4'(i * 15 / 2);
         lat = ddyn ? dsel + 4 : 7;
         src.set_pad(1'b0);
         cyc(24);
         src.set_pad(1'b1);
         cyc(lat - 1);
         check(4'(sdr), 4'h0);
         cyc(1);
         check(4'(sdr), 4'h1);
      end
      den = 1'b0;
      ce = 1'b0;
      src.set_pad(1'b0);
      cyc(6);
      check(4'(sdr), 4'h1);
      ce = 1'b1;
      cyc(4);
      check(4'(sdr), 4'h0);
      mode = `PICG_MODE_DDR;
      cyc(2);
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         inv = i[2];
         rdy = rnd[2] | rnd[3];
         pair(rnd[0], rnd[1], 1'b1);
      end
      rdy = 1'b1;
      cyc(20);
      check(4'(qd.size() != 0), 4'h0);
      for (int i = 0; i < 2; i++) begin
         inv = i[0];
         pair(1'b1, 1'b0, 1'b1);
         cyc(2 + i);
         check(4'(dv), 4'h0);
         cyc(1);
         check(4'(dv), 4'h1);
      end
      // core stalls: sixteen pairs fit, the seventeenth is lost
      rdy = 1'b0;
      for (int i = 0; i < 17; i++) begin
         rnd = lfsr(rnd);
         pair(rnd[0], rnd[1], i < 16);
      end
      cyc(6);
      check({2'h0, crdy, ovr}, 4'h1);
      rdy = 1'b1;
      cyc(24);
      check({2'h0, crdy, ovr}, 4'h3);
      check(4'(qd.size() != 0), 4'h0);
      mode = `PICG_MODE_GEAR;
      cyc(2);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         if (i[0])
            qg.push_back({q4[0], q4[1], rnd[0], rnd[1]});
         q4 = rnd[1:0];
         pair(rnd[0], rnd[1], 1'b0);
      end
      cyc(12);
      check(4'(qg.size() != 0), 4'h0);
      mode = `PICG_MODE_SDR;
      cyc(3);
      check(4'(ovr), 4'h0);
      tally_and_finish;
   end
endmodule
`default_nettype wire
